// file: bench/sosc_host.sv
// Host processor model: register bus cycles and the chip-select wake pin.
module sosc_host (
    // Clock
    input  wire logic               ref_clk,
    // Register bus
    output sosc_pkg::sosc_bus_req_t bus_req,
    input  wire logic [7:0]         rd_data,
    input  wire logic               bus_ready,
    // Chip-select and wake pin
    output logic                    wake_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    import sosc_pkg::*;

    // Idle lines at time zero; the select pin idles high.
    initial begin
        bus_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hE6, wdata: 8'h19};
        wake_pin = 1'b1;
    end

    // One access held up to its sampling edge, then one idle cycle follows.
    // Released address and data show the inverse so stale values never match.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        bus_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk);
        #2;
        bus_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge ref_clk);
        #2;
    endtask

    // Wake: move the pin off its level, then hold off the bus until served again.
    task automatic wake(output int cyc);
        wake_pin = !wake_pin;
        cyc = 0;
        while (bus_ready !== 1'b1 && cyc < 100) begin
            @(posedge ref_clk);
            #2;
            cyc++;
        end
    endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the output select and shutdown register block.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sosc_pkg::*;

    localparam int B1 = 8;
    localparam int B2 = 8;
    logic                     ref_clk = 1'b0, resetn = 1'b0;
    sosc_bus_req_t            bus_req;
    sosc_cfg_t                cfg_out;
    logic [7:0]               rd_data, burst_next_addr, burst_addr = 8'h00;
    logic                     bus_ready, burst_step = 1'b0, wake_pin, sleep_request = 1'b0;
    logic                     motion_detect_input = 1'b0, boot_strap_select = 1'b0;
    logic                     odr_tick = 1'b0, magnitude_valid, powered, motion_active;
    logic signed [AXIS_W-1:0] x_in = '0, y_in = '0, z_in = '0;
    logic [1:0]               cd_source_select = 2'h0, power_mode;
    logic [1:0]               awake_power_mode = 2'h2, dormant_power_mode = 2'h1;
    logic [AXIS_W-1:0]        cd_axis_value = '0, cd_value, magnitude_result, m_last;
    logic [7:0]               exp_rd[$], exp_bn[$];
    logic [AXIS_W-1:0]        exp_mag[$];
    logic                     rd_q = 1'b0, bn_q = 1'b0;
    int                       fails = 0, total_checks = 0, seed = 96, n;

    always #50 ref_clk = ~ref_clk;

    sosc_top #(.BOOT1_CYCLES(B1), .BOOT2_CYCLES(B2)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req), .cfg_out(cfg_out),
        .rd_data(rd_data), .bus_ready(bus_ready), .burst_step(burst_step),
        .burst_addr(burst_addr), .burst_next_addr(burst_next_addr), .wake_pin(wake_pin),
        .motion_detect_input(motion_detect_input), .boot_strap_select(boot_strap_select),
        .odr_tick(odr_tick), .x_in(x_in), .y_in(y_in), .z_in(z_in),
        .cd_source_select(cd_source_select), .cd_axis_value(cd_axis_value),
        .cd_value(cd_value), .magnitude_result(magnitude_result),
        .magnitude_valid(magnitude_valid), .awake_power_mode(awake_power_mode),
        .dormant_power_mode(dormant_power_mode), .sleep_request(sleep_request),
        .power_mode(power_mode), .powered(powered), .motion_active(motion_active)
    );

    sosc_host host_u (
        .ref_clk(ref_clk), .bus_req(bus_req), .rd_data(rd_data),
        .bus_ready(bus_ready), .wake_pin(wake_pin)
    );

    // One comparison; an unknown seen value never passes.
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask

    // Next included burst address, from the pair layout and the exclude bits.
    function automatic logic [7:0] nxt(input logic [7:0] a, input logic [4:0] c);
        logic [7:0] v;
        v = a + 8'h01;
        repeat (8) begin
            if ((v[7:1] == 7'h02 && c[3]) || (v[7:1] == 7'h03 && c[2]) ||
                (v[7:1] == 7'h04 && c[1]) || (v[7:1] == 7'h05 && !c[4])) begin
                v = v + 8'h01;
            end
        end
        return v;
    endfunction

    function automatic logic [11:0] isqrt(input int v);
        int r;
        r = 0;
        while ((r + 1) * (r + 1) <= v) r++;
        return r[11:0];
    endfunction

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        host_u.access(1'b0, a, 8'h00);
    endtask

    task automatic step(input logic [7:0] a, input logic [4:0] c);
        exp_bn.push_back(nxt(a, c));
        burst_step = 1'b1;
        burst_addr = a;
        cyc(1);
        burst_step = 1'b0;
        burst_addr = ~a;
        cyc(1);
    endtask

    // One sample tick; axes hold until the result is due.
    task automatic mag(input logic en);
        x_in = 12'($random(seed));
        y_in = 12'($random(seed));
        z_in = 12'($random(seed));
        m_last = isqrt(int'(x_in) * x_in + int'(y_in) * y_in + int'(z_in) * z_in);
        if (en) exp_mag.push_back(m_last);
        odr_tick = 1'b1;
        cyc(1);
        odr_tick = 1'b0;
        cyc(13);
        chk("magnitude_valid", 12'(en), 12'(magnitude_valid));
        cyc(4);
    endtask

    // Results are sampled mid-cycle, half a cycle after the edge that took the request.
    always @(posedge ref_clk) begin
        rd_q <= bus_req.rd;
        bn_q <= burst_step;
    end
    always @(negedge ref_clk) begin
        if (rd_q === 1'b1) chk("rd_data", exp_rd.size() ? exp_rd.pop_front() : 8'hA5, rd_data);
        if (bn_q === 1'b1) chk("burst_next", exp_bn.size() ? exp_bn.pop_front() : 8'hA5,
                               burst_next_addr);
        if (magnitude_valid !== 1'b0) chk("magnitude_result",
                               exp_mag.size() ? exp_mag.pop_front() : ~m_last, magnitude_result);
    end

    // A hang is cut short well after the expected few hundred cycles.
    initial begin
        #3000000;
        fails++;
        end_of_test();
    end

    initial begin
        cyc(4);
        resetn = 1'b1;
        cyc(8);
        chk("cfg_out", 12'h000, {4'h0, cfg_out});
        rd(CFG_ADDR, CFG_RESET);
        rd(8'h55, RD_IDLE);
        // Random writes keep shutdown clear; top bits must read back zero.
        repeat (4) begin
            n = $random(seed) & 8'hFE;
            host_u.access(1'b1, CFG_ADDR, n[7:0]);
            rd(CFG_ADDR, n[7:0] & 8'h1E);
        end
        // Every exclude combination against every pair boundary.
        for (int c = 0; c < 16; c++) begin
            host_u.access(1'b1, CFG_ADDR, 8'(c << 1));
            for (int a = 3; a < 12; a += 2) begin
                step(8'(a), 5'(c << 1));
            end
        end
        host_u.access(1'b1, CFG_ADDR, 8'h00);
        mag(1'b0);
        host_u.access(1'b1, CFG_ADDR, 8'h10);
        repeat (3) mag(1'b1);
        rd(MAG_LOW_ADDR, m_last[7:0]);
        rd(MAG_LOW_ADDR + 8'h01, {4'h0, m_last[11:8]});
        cd_source_select = CD_SRC_MAG;
        cd_axis_value = 12'($random(seed));
        cyc(2);
        chk("cd_value", m_last, cd_value);
        cd_source_select = 2'h2;
        cyc(2);
        chk("cd_value", cd_axis_value, cd_value);
        for (int s = 0; s < 2; s++) begin
            sleep_request = s[0];
            cyc(2);
            chk("power_mode", s ? 12'h1 : 12'h2, 12'(power_mode));
        end
        host_u.access(1'b1, CFG_ADDR, 8'h11);
        chk("bus_ready", 12'h0, 12'(bus_ready));
        chk("cfg_out", 12'h000, {4'h0, cfg_out});
        chk("power_mode", 12'h0, 12'(power_mode));
        // Accesses in shutdown are refused; no edge on the pin means no exit.
        host_u.access(1'b1, CFG_ADDR, 8'h10);
        rd(CFG_ADDR, RD_IDLE);
        cyc(20);
        chk("powered", 12'h0, 12'(powered));
        host_u.wake(n);
        chk("wake_cycles", 12'h1, 12'(n >= B1 && n <= B1 + 8));
        rd(CFG_ADDR, CFG_RESET);
        // Second reset with the strap high: the motion pin alone runs the power state.
        resetn = 1'b0;
        boot_strap_select = 1'b1;
        cyc(4);
        resetn = 1'b1;
        cyc(10);
        chk("powered", 12'h0, 12'(powered));
        motion_detect_input = 1'b1;
        n = 0;
        while (powered !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk("boot_cycles", 12'h1, 12'(n >= B2 && n <= B2 + 8));
        chk("motion_active", 12'h1, 12'(motion_active));
        motion_detect_input = 1'b0;
        cyc(6);
        chk("powered", 12'h0, 12'(powered));
        chk("notes_left", 12'h0, 12'(exp_rd.size() + exp_bn.size() + exp_mag.size()));
        end_of_test();
    end
endmodule

// file: common/sosc_pkg.sv
// Shared constants, types and helpers for the sensor output select block.
package sosc_pkg;
    // Register map and burst data range.
    localparam logic [7:0] CFG_ADDR     = 8'h19;
    localparam logic [7:0] X_LOW_ADDR   = 8'h04;
    localparam logic [7:0] Y_LOW_ADDR   = 8'h06;
    localparam logic [7:0] Z_LOW_ADDR   = 8'h08;
    localparam logic [7:0] MAG_LOW_ADDR = 8'h0A;
    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] CFG_MASK     = 8'h1F;
    localparam logic [7:0] RD_IDLE      = 8'h00;
    localparam int         BURST_SKIPS  = 8;

    // Timing: clock rate and boot intervals.
    localparam int CLK_KHZ    = 10000;
    localparam int BOOT1_US   = 1000;
    localparam int BOOT2_US   = 1000;
    localparam int BOOT1_CYC  = (BOOT1_US * CLK_KHZ + 999) / 1000;
    localparam int BOOT2_CYC  = (BOOT2_US * CLK_KHZ + 999) / 1000;
    localparam int BOOT_CNT_W = 16;
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    // Data path widths and the change detection source code for magnitude.
    localparam int AXIS_W  = 12;
    localparam int SUMSQ_W = 24;
    localparam logic [1:0] CD_SRC_MAG = 2'h1;

    typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_SHUT, ST_BOOT} sosc_pstate_t;

    // Bit layout of the configuration register, bit 7 first.
    typedef struct packed {
        logic [2:0] unused;
        logic       magnitude_calc_enable;
        logic       first_axis_read_exclude;
        logic       second_axis_read_exclude;
        logic       third_axis_read_exclude;
        logic       shutdown_cmd;
    } sosc_cfg_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sosc_sync_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sosc_bus_req_t;

    typedef struct packed {
        sosc_pstate_t            st;
        sosc_cfg_t               cfg;
        sosc_sync_t              wake;
        sosc_sync_t              mot;
        sosc_sync_t              strap;
        logic                    strap_hi;
        logic [1:0]              settle;
        logic                    wake_ref;
        logic [BOOT_CNT_W-1:0]   cnt;
        logic [7:0]              rd_data;
        logic [7:0]              burst_next;
        logic                    bus_ready;
        logic [1:0]              pmode;
        logic                    powered;
        logic                    motion_active;
        logic [AXIS_W-1:0]       cd_value;
        logic                    mag_start;
    } sosc_top_st_t;

    typedef struct packed {
        logic                busy;
        logic [SUMSQ_W-1:0]  sum;
        logic [AXIS_W-1:0]   res;
        logic [3:0]          idx;
        logic [AXIS_W-1:0]   result;
        logic                valid;
    } sosc_mag_st_t;

    // One step of a three-stage pin synchroniser; the level moves only when stages agree.
    function automatic sosc_sync_t sosc_sync_step(input sosc_sync_t s, input logic pin);
        sosc_sync_t n;
        n = s;
        n.s1 = pin;
        n.s2 = s.s1;
        n.s3 = s.s2;
        if (s.s2 == s.s3) begin
            n.lvl = s.s3;
        end
        return n;
    endfunction

    // True when an address is left out of the burst sequence.
    function automatic logic sosc_excluded(input logic [7:0] a, input sosc_cfg_t c);
        logic [6:0] p;
        p = a[7:1];
        return (p == X_LOW_ADDR[7:1] && c.first_axis_read_exclude)
            || (p == Y_LOW_ADDR[7:1] && c.second_axis_read_exclude)
            || (p == Z_LOW_ADDR[7:1] && c.third_axis_read_exclude)
            || (p == MAG_LOW_ADDR[7:1] && !c.magnitude_calc_enable);
    endfunction

    // Next burst address, stepping over every excluded address.
    function automatic logic [7:0] sosc_burst_next(input logic [7:0] a, input sosc_cfg_t c);
        logic [7:0] n;
        n = a + 8'h01;
        for (int i = 0; i < BURST_SKIPS; i++) begin
            if (sosc_excluded(n, c)) begin
                n = n + 8'h01;
            end
        end
        return n;
    endfunction
endpackage

// file: core/sosc_mag.sv
// Iterative vector magnitude unit: square root of the sum of squared axis values.
module sosc_mag (
    // Clock and reset
    input  wire logic                            ref_clk,
    input  wire logic                            resetn,
    // Control
    input  wire logic                            start,
    input  wire logic                            clear,
    // Axis samples, two's complement
    input  wire logic signed [sosc_pkg::AXIS_W-1:0] x_in,
    input  wire logic signed [sosc_pkg::AXIS_W-1:0] y_in,
    input  wire logic signed [sosc_pkg::AXIS_W-1:0] z_in,
    // Result
    output logic             [sosc_pkg::AXIS_W-1:0] result,
    output logic                                 valid,
    output logic                                 busy
);
    import sosc_pkg::*;

    sosc_mag_st_t s_r;
    sosc_mag_st_t s_nxt;

    // Square of the absolute value; the most negative code maps to 2048 without overflow.
    function automatic logic [SUMSQ_W-1:0] sq(input logic signed [AXIS_W-1:0] v);
        logic [AXIS_W-1:0] m;
        m = v[AXIS_W-1] ? AXIS_W'(-v) : AXIS_W'(v);
        return SUMSQ_W'(m) * SUMSQ_W'(m);
    endfunction

    // One result bit per cycle keeps the multiplier small at the cost of twelve cycles.
    always_comb begin
        logic [AXIS_W-1:0]  trial;
        logic [SUMSQ_W-1:0] t2;
        trial = '0;
        t2 = '0;
        s_nxt = s_r;
        s_nxt.valid = 1'b0;
        if (clear) begin
            s_nxt = '0;
        end else if (!s_r.busy && start) begin
            s_nxt.busy = 1'b1;
            s_nxt.sum = sq(x_in) + sq(y_in) + sq(z_in);
            s_nxt.res = '0;
            s_nxt.idx = 4'hB;
        end else if (s_r.busy) begin
            trial = s_r.res | (12'h001 << s_r.idx);
            t2 = SUMSQ_W'(trial) * SUMSQ_W'(trial);
            if (t2 <= s_r.sum) begin
                s_nxt.res = trial;
            end
            if (s_r.idx == 4'h0) begin
                s_nxt.busy = 1'b0;
                s_nxt.valid = 1'b1;
                s_nxt.result = s_nxt.res;
            end else begin
                s_nxt.idx = s_r.idx - 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign result = s_r.result;
    assign valid  = s_r.valid;
    assign busy   = s_r.busy;
endmodule

// file: core/sosc_top.sv
// Output select and shutdown configuration register with its power sequencer.
//
// Summary of operation
// - Magnitude disabled: no calculation, magnitude not burst-read.
// - Magnitude enabled: compute per sample, burst-read both.
// - Source select one feeds magnitude to change detection.
// - First axis exclude bit drops it from bursts.
// - Second axis exclude bit drops it from bursts.
// - Third axis exclude bit drops it from bursts.
// - Shutdown clear: follow selected wake or sleep mode.
// - Shutdown write enters shutdown, discarding all registers.
// - Strap low: wake pin edge alone ends shutdown.
// - Strap high: motion input high boots into active.
// - Strap high: motion input low forces shutdown.
// - Register resets to zero; bits 7..5 read zero.
module sosc_top #(
    parameter int BOOT1_CYCLES = sosc_pkg::BOOT1_CYC,
    parameter int BOOT2_CYCLES = sosc_pkg::BOOT2_CYC
) (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,

    // Register access from the serial port
    input  wire sosc_pkg::sosc_bus_req_t       bus_req,
    output sosc_pkg::sosc_cfg_t                cfg_out,
    output logic [7:0]                         rd_data,
    output logic                               bus_ready,

    // Burst read address stepping
    input  wire logic                          burst_step,
    input  wire logic [7:0]                    burst_addr,
    output logic [7:0]                         burst_next_addr,

    // Pins
    input  wire logic                          wake_pin,
    input  wire logic                          motion_detect_input,
    input  wire logic                          boot_strap_select,

    // Sample path
    input  wire logic                          odr_tick,
    input  wire logic signed [sosc_pkg::AXIS_W-1:0] x_in,
    input  wire logic signed [sosc_pkg::AXIS_W-1:0] y_in,
    input  wire logic signed [sosc_pkg::AXIS_W-1:0] z_in,
    input  wire logic [1:0]                    cd_source_select,
    input  wire logic [sosc_pkg::AXIS_W-1:0]   cd_axis_value,
    output logic [sosc_pkg::AXIS_W-1:0]        cd_value,
    output logic [sosc_pkg::AXIS_W-1:0]        magnitude_result,
    output logic                               magnitude_valid,

    // Power state
    input  wire logic [1:0]                    awake_power_mode,
    input  wire logic [1:0]                    dormant_power_mode,
    input  wire logic                          sleep_request,
    output logic [1:0]                         power_mode,
    output logic                               powered,
    output logic                               motion_active
);
    import sosc_pkg::*;

    // Boot interval loads and the counter step.
    localparam logic [BOOT_CNT_W-1:0] B1 = BOOT_CNT_W'(BOOT1_CYCLES);
    localparam logic [BOOT_CNT_W-1:0] B2 = BOOT_CNT_W'(BOOT2_CYCLES);
    localparam logic [BOOT_CNT_W-1:0] CNT_ONE = 16'h0001;

    // Registered state, its next value and a few helper nets.
    sosc_top_st_t s_r;
    sosc_top_st_t s_nxt;
    logic         cfg_wr;
    logic         mag_busy;
    logic         mag_clear;
    logic [AXIS_W-1:0] mag_res;

    // Write strobe for this register and the hold on the magnitude unit.
    assign cfg_wr = bus_req.wr && bus_req.addr == CFG_ADDR;
    assign mag_clear = s_r.st != ST_RUN;

    // Magnitude unit; held cleared whenever the device is not running.
    sosc_mag u_mag (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (s_r.mag_start),
        .clear   (mag_clear),
        .x_in    (x_in),
        .y_in    (y_in),
        .z_in    (z_in),
        .result  (mag_res),
        .valid   (magnitude_valid),
        .busy    (mag_busy)
    );

    // Power sequencer, register file and burst stepping in one next-state process.
    always_comb begin
        s_nxt = s_r;
        s_nxt.wake = sosc_sync_step(s_r.wake, wake_pin);
        s_nxt.mot = sosc_sync_step(s_r.mot, motion_detect_input);
        s_nxt.strap = sosc_sync_step(s_r.strap, boot_strap_select);
        s_nxt.mag_start = 1'b0;

        unique case (s_r.st)
            // The strap is taken once the synchroniser has had time to fill.
            ST_INIT: begin
                s_nxt.settle = s_r.settle + 2'h1;
                if (s_r.settle == SETTLE_LAST) begin
                    // The synchronisers restart with reset, so take the level now settling.
                    s_nxt.strap_hi = s_nxt.strap.lvl;
                    if (!s_nxt.strap.lvl) begin
                        s_nxt.st = ST_RUN;
                    end else if (s_nxt.mot.lvl) begin
                        s_nxt.st = ST_BOOT;
                        s_nxt.cnt = B2;
                    end else begin
                        s_nxt.st = ST_SHUT;
                    end
                end
            end

            ST_RUN: begin
                // Writes land only while running.
                if (cfg_wr) begin
                    s_nxt.cfg = sosc_cfg_t'(bus_req.wdata & CFG_MASK);
                end
                if (s_r.strap_hi && !s_r.mot.lvl) begin
                    s_nxt.st = ST_SHUT;
                end else if (cfg_wr && bus_req.wdata[0]) begin
                    s_nxt.st = ST_SHUT;
                    s_nxt.wake_ref = s_r.wake.lvl;
                end
                // Ticks that land while a calculation is running are dropped.
                s_nxt.mag_start = s_r.cfg.magnitude_calc_enable && odr_tick
                                  && !mag_busy;
            end

            ST_SHUT: begin
                // Strap low waits for a wake edge, strap high for the motion level.
                if (!s_r.strap_hi && s_r.wake.lvl != s_r.wake_ref) begin
                    s_nxt.st = ST_BOOT;
                    s_nxt.cnt = B1;
                end else if (s_r.strap_hi && s_r.mot.lvl) begin
                    s_nxt.st = ST_BOOT;
                    s_nxt.cnt = B2;
                end
            end

            // Bus stays deaf for the whole interval the host is told to wait.
            ST_BOOT: begin
                if (s_r.strap_hi && !s_r.mot.lvl) begin
                    s_nxt.st = ST_SHUT;
                end else if (s_r.cnt <= CNT_ONE) begin
                    s_nxt.st = ST_RUN;
                end else begin
                    s_nxt.cnt = s_r.cnt - CNT_ONE;
                end
            end
        endcase

        // Leaving run discards the register as a supply loss would.
        if (s_nxt.st == ST_SHUT || s_nxt.st == ST_BOOT) begin
            s_nxt.cfg = sosc_cfg_t'(CFG_RESET);
        end

        // Reads outside run return zero; the bus is not served then.
        if (bus_req.rd) begin
            if (s_r.st != ST_RUN) begin
                s_nxt.rd_data = RD_IDLE;
            end else if (bus_req.addr == CFG_ADDR) begin
                s_nxt.rd_data = s_r.cfg;
            end else if (bus_req.addr == MAG_LOW_ADDR) begin
                s_nxt.rd_data = mag_res[7:0];
            end else if (bus_req.addr == MAG_LOW_ADDR + 8'h01) begin
                s_nxt.rd_data = {4'h0, mag_res[11:8]};
            end else begin
                s_nxt.rd_data = RD_IDLE;
            end
        end

        // Ready follows the state being entered, so it rises with run.
        s_nxt.bus_ready = s_nxt.st == ST_RUN;

        // Burst stepping uses the register as it stands.
        if (burst_step) begin
            s_nxt.burst_next = sosc_burst_next(burst_addr, s_r.cfg);
        end

        // Change detection takes the magnitude or the axis value.
        if (cd_source_select == CD_SRC_MAG) begin
            s_nxt.cd_value = mag_res;
        end else begin
            s_nxt.cd_value = cd_axis_value;
        end

        // Power mode is forced off outside run.
        s_nxt.powered = s_nxt.st == ST_RUN;
        if (!s_nxt.powered) begin
            s_nxt.pmode = 2'h0;
        end else if (sleep_request) begin
            s_nxt.pmode = dormant_power_mode;
        end else begin
            s_nxt.pmode = awake_power_mode;
        end

        // Motion mode is reported only for a strap-high boot.
        s_nxt.motion_active = s_nxt.powered && s_r.strap_hi;
    end

    // Constant reset gives the init state and a zeroed register.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the registered state.
    assign cfg_out          = s_r.cfg;
    assign rd_data          = s_r.rd_data;
    assign bus_ready        = s_r.bus_ready;
    assign burst_next_addr  = s_r.burst_next;
    assign cd_value         = s_r.cd_value;
    assign magnitude_result = mag_res;
    assign power_mode       = s_r.pmode;
    assign powered          = s_r.powered;
    assign motion_active    = s_r.motion_active;

    // Checks on the sequencer and register behaviour.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    mag_skip_a: assert property (!s_r.cfg.magnitude_calc_enable |=> !s_r.mag_start)
        else $error("magnitude started while disabled");

    mag_run_a: assert property (
        s_r.st == ST_RUN && s_r.cfg.magnitude_calc_enable && odr_tick && !mag_busy
        && !(s_r.strap_hi && !s_r.mot.lvl) && !(cfg_wr && bus_req.wdata[0])
        |=> s_r.mag_start ##1 mag_busy ##12 magnitude_valid)
        else $error("magnitude not produced on time");

    cd_source_a: assert property (cd_source_select == CD_SRC_MAG |=>
        cd_value == $past(mag_res))
        else $error("change detection not fed by magnitude");

    cd_axis_a: assert property (cd_source_select != CD_SRC_MAG |=>
        cd_value == $past(cd_axis_value))
        else $error("change detection axis input lost");

    burst_skip_a: assert property (burst_step |=>
        !sosc_excluded(burst_next_addr, $past(s_r.cfg)))
        else $error("burst landed on an excluded address");

    cfg_write_a: assert property (s_r.st == ST_RUN && cfg_wr && !bus_req.wdata[0]
        && !(s_r.strap_hi && !s_r.mot.lvl) |=>
        cfg_out == $past(bus_req.wdata & CFG_MASK))
        else $error("register write not stored");

    unused_zero_a: assert property (cfg_out.unused == 3'h0)
        else $error("unused register bits set");

    shut_cmd_a: assert property (s_r.st == ST_RUN && cfg_wr && bus_req.wdata[0] |=>
        s_r.st == ST_SHUT && cfg_out == CFG_RESET && !powered)
        else $error("shutdown command not honoured");

    pmode_off_a: assert property (!powered |-> power_mode == 2'h0)
        else $error("power mode active while off");

    pmode_sel_a: assert property (s_nxt.powered |=> power_mode ==
        $past(sleep_request ? dormant_power_mode : awake_power_mode))
        else $error("selected power mode not followed");

    wake_edge_a: assert property (s_r.st == ST_SHUT && !s_r.strap_hi |=>
        (s_r.st == ST_BOOT) == $past(s_r.wake.lvl != s_r.wake_ref))
        else $error("wake edge handling wrong");

    motion_boot_a: assert property (s_r.st == ST_SHUT && s_r.strap_hi
        && s_r.mot.lvl |=> s_r.st == ST_BOOT && s_r.cnt == B2)
        else $error("motion level did not start boot");

    motion_low_a: assert property ((s_r.st == ST_RUN || s_r.st == ST_BOOT)
        && s_r.strap_hi && !s_r.mot.lvl |=> s_r.st == ST_SHUT)
        else $error("motion low did not shut down");

    boot_end_a: assert property (s_r.st == ST_BOOT && s_r.cnt == CNT_ONE
        && !(s_r.strap_hi && !s_r.mot.lvl) |=> s_r.st == ST_RUN ##1 bus_ready)
        else $error("boot interval end wrong");

    bus_deaf_a: assert property (s_r.st != ST_RUN && s_nxt.st != ST_RUN
        && bus_req.rd |=> $stable(cfg_out) && rd_data == RD_IDLE && !bus_ready)
        else $error("bus served outside run");

    mag_idle_a: assert property (!s_r.cfg.magnitude_calc_enable && !mag_busy |=>
        !magnitude_valid)
        else $error("magnitude produced while disabled");

    // Main scenarios that the bench should reach.
    shut_cover_c: cover property (s_r.st == ST_RUN ##1 s_r.st == ST_SHUT);
    wake_cover_c: cover property (s_r.st == ST_SHUT && !s_r.strap_hi ##1 s_r.st == ST_BOOT);
    motion_cover_c: cover property (s_r.st == ST_SHUT && s_r.strap_hi ##1 s_r.st == ST_BOOT);
    mag_cover_c: cover property (magnitude_valid);
    boot_cover_c: cover property (s_r.st == ST_BOOT ##1 s_r.st == ST_RUN);
endmodule
